// ---- hw/reset_sequencer.sv ----
/*
 * Reset source merger, power-up timer and reset cause flags.
 * Assumes all inputs synchronous to sys_clk, nrst is the power-on
 * reset of this block, and an Avalon-MM master with waitrequest.
 */
// How it works
// - A low external reset pin holds the core in reset.
// - Short low pulses on the reset pin are filtered out.
// - The reset pin is input only; nothing here drives it.
// - Power-on indication raises a reset so the core starts initialized.
// - Power-on reset clears the power-on flag; a software write of zero also clears it.
// - Only software sets the power-on flag back to one.
// - Brown-out works only with the regulator enable pin high.
// - Brown-out indication holds reset until regulator output recovers.
// - After brown-out ends, the power-up timer runs its full delay.
// - Brown-out during the timer returns to reset and restarts the delay.
// - Brown-out and power-on resets clear the brown-out flag.
// - With regulator off, brown-out flag ignores events; power-on still clears.
// - Configuration words are compared with shadows; mismatch triggers reset.
// - Mismatch reset clears the mismatch flag; a software write of zero also clears it.
// - Every hard or power reset reloads configuration before restart.
// - The power-up timer cannot be bypassed.
// - Timer is 11 bits counting 2048 RC periods of 32 us.
// - Core stays in reset while the timer counts.
// - Timer starts only after the power-on pulse ends.
// - Pin held past timer expiry releases the core at once.
`timescale 1ns/1ps
`default_nettype none

module reset_sequencer
   import reset_seq_pkg::*;
#(
   parameter int TICK_CYCLES = RC_TICK_CYCLES
)
(
   // Clock and reset
   input  wire logic                sys_clk,
   input  wire logic                nrst,
   // Supply monitors and pins
   input  wire logic                por_active,
   input  wire logic                brownout_detect,
   input  wire logic                regulator_enable_pin,
   input  wire logic                ext_reset_n_pin,
   // Configuration compare and reload
   input  wire logic [CFG_BITS-1:0] cfg_words,
   input  wire logic [CFG_BITS-1:0] cfg_shadow,
   output logic                     cfg_reload,
   input  wire logic                cfg_reload_done,
   // Core reset
   output logic                     core_reset_n,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0]   avs_address,
   input  wire logic                avs_read,
   input  wire logic                avs_write,
   input  wire logic [31:0]         avs_writedata,
   input  wire logic [3:0]          avs_byteenable,
   output logic [31:0]              avs_readdata,
   output logic                     avs_waitrequest
);

   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   seq_regs_t r;
   seq_regs_t next_r;

   logic pin_reset;
   logic bor_eff;
   logic power_src;
   logic mismatch;
   logic tick;
   logic flags_wr;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Shadows hold the complement of each configuration bit
   function automatic logic cfg_differs(input logic [CFG_BITS-1:0] w,
                                        input logic [CFG_BITS-1:0] s);
      cfg_differs = ((w ^ s) != {CFG_BITS{1'b1}});
   endfunction : cfg_differs

   function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a,
                                             input seq_regs_t        q,
                                             input logic             pin,
                                             input logic             pwr,
                                             input logic             core_n);
      logic [31:0] w;
      w = 32'h0;
      if (a == OFS_FLAGS) begin
         w[BIT_BOR] = q.bor_flag;
         w[BIT_POR] = q.por_flag;
         w[BIT_CM]  = q.cm_flag;
      end else if (a == OFS_STATUS) begin
         w[STS_POWER]  = pwr;
         w[STS_PIN]    = pin;
         w[STS_TIMER]  = (q.st == S_TIMER);
         w[STS_RELOAD] = (q.st == S_RELOAD);
         w[STS_CORE]   = ~core_n;
         w[STS_CNT_LSB +: PUT_W] = q.put_cnt;
      end
      read_word = w;
   endfunction : read_word

   // ---------------------------------------------------------------
   // Reset pin filter
   // ---------------------------------------------------------------
   // The pin is only ever sampled; no output reaches it
   pin_noise_filter u_pin_filter (
      .sys_clk         (sys_clk),
      .nrst            (nrst),
      .ext_reset_n_pin (ext_reset_n_pin),
      .pin_reset       (pin_reset)
   );

   // ---------------------------------------------------------------
   // Source qualification
   // ---------------------------------------------------------------
   assign bor_eff   = brownout_detect & regulator_enable_pin;
   assign power_src = por_active | bor_eff;
   assign mismatch  = cfg_differs(cfg_words, cfg_shadow);
   assign tick      = (r.tick_cnt == TICK_LAST);
   assign flags_wr  = avs_write & r.ack & (avs_address == OFS_FLAGS) & avs_byteenable[0];

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_r = r;

      // Bus: one wait cycle, read word captured as the wait ends
      next_r.ack = (avs_read | avs_write) & ~r.ack;
      if (avs_read & ~r.ack) begin
         next_r.rdata = read_word(avs_address, r, pin_reset, power_src, core_reset_n);
      end

      // Software restores cause flags
      if (flags_wr) begin
         next_r.bor_flag = avs_writedata[BIT_BOR];
         next_r.por_flag = avs_writedata[BIT_POR];
         next_r.cm_flag  = avs_writedata[BIT_CM];
      end

      case (r.st)
         S_POWER: begin
            next_r.put_cnt  = '0;
            next_r.tick_cnt = '0;
            if (!power_src) begin
               next_r.st = S_TIMER;
            end
         end
         S_TIMER: begin
            // Always entered after a power event; no bypass path
            if (tick) begin
               next_r.tick_cnt = '0;
               if (r.put_cnt == PUT_LAST) begin
                  next_r.st          = S_RELOAD;
                  next_r.reload_seen = 1'b0;
               end else begin
                  next_r.put_cnt = r.put_cnt + PUT_W'(1);
               end
            end else begin
               next_r.tick_cnt = r.tick_cnt + TICK_W'(1);
            end
         end
         S_RELOAD: begin
            if (cfg_reload_done) begin
               next_r.reload_seen = 1'b1;
            end
            if ((r.reload_seen | cfg_reload_done) & ~pin_reset) begin
               next_r.st = S_RUN;
            end
         end
         S_RUN: begin
            if (pin_reset) begin
               next_r.st          = S_RELOAD;
               next_r.reload_seen = 1'b0;
            end else if (mismatch) begin
               next_r.st          = S_RELOAD;
               next_r.reload_seen = 1'b0;
               next_r.cm_flag     = 1'b0;
            end
         end
         default: begin
            next_r.st = S_POWER;
         end
      endcase

      // Power events override everything and restart the delay
      if (power_src) begin
         next_r.st       = S_POWER;
         next_r.put_cnt  = '0;
         next_r.tick_cnt = '0;
      end

      // Hardware clears win over a software write in the same cycle
      if (por_active) begin
         next_r.por_flag = 1'b0;
         next_r.bor_flag = 1'b0;
      end
      if (bor_eff) begin
         next_r.bor_flag = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         r             <= '0;
         r.st          <= S_POWER;
         r.bor_flag    <= RST_BOR;
         r.por_flag    <= RST_POR;
         r.cm_flag     <= RST_CM;
      end else begin
         r <= next_r;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Power and pin sources pull reset at once, mismatch one clock later; release only follows a clocked state
   assign core_reset_n    = nrst & ~power_src & ~pin_reset & (r.st == S_RUN);
   assign cfg_reload      = (r.st == S_RELOAD) & ~r.reload_seen;
   assign avs_waitrequest = (avs_read | avs_write) & ~r.ack;
   assign avs_readdata    = r.rdata;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_pin_holds;
      @(posedge sys_clk) disable iff (!nrst)
      pin_reset |-> !core_reset_n;
   endproperty
   a_pin_holds: assert property (p_pin_holds)
      else $error("core released while pin reset active");

   property p_por_holds;
      @(posedge sys_clk) disable iff (!nrst)
      por_active |-> !core_reset_n ##1 (r.st == S_POWER);
   endproperty
   a_por_holds: assert property (p_por_holds)
      else $error("power-on indication did not hold reset");

   property p_por_flag_clear;
      @(posedge sys_clk) disable iff (!nrst)
      por_active |=> !r.por_flag && !r.bor_flag;
   endproperty
   a_por_flag_clear: assert property (p_por_flag_clear)
      else $error("power-on reset left a cause flag set");

   property p_por_flag_sw_only;
      @(posedge sys_clk) disable iff (!nrst)
      $rose(r.por_flag) |-> $past(flags_wr && avs_writedata[BIT_POR]);
   endproperty
   a_por_flag_sw_only: assert property (p_por_flag_sw_only)
      else $error("power-on flag set without a software write");

   property p_bor_needs_reg;
      @(posedge sys_clk) disable iff (!nrst)
      (!regulator_enable_pin && !por_active && !flags_wr && r.bor_flag) |=> r.bor_flag;
   endproperty
   a_bor_needs_reg: assert property (p_bor_needs_reg)
      else $error("brown-out flag changed with regulator off");

   property p_bor_holds;
      @(posedge sys_clk) disable iff (!nrst)
      bor_eff |-> !core_reset_n ##1 (!r.bor_flag && r.st == S_POWER && r.put_cnt == '0);
   endproperty
   a_bor_holds: assert property (p_bor_holds)
      else $error("brown-out did not hold reset and restart the timer");

   property p_timer_full;
      @(posedge sys_clk) disable iff (!nrst)
      ($rose(r.st == S_RELOAD) && $past(r.st == S_TIMER)) |-> $past(r.put_cnt) == PUT_LAST;
   endproperty
   a_timer_full: assert property (p_timer_full)
      else $error("power-up timer ended early");

   property p_timer_holds;
      @(posedge sys_clk) disable iff (!nrst)
      (r.st == S_TIMER) |-> !core_reset_n;
   endproperty
   a_timer_holds: assert property (p_timer_holds)
      else $error("core released while the timer runs");

   property p_mismatch_reset;
      @(posedge sys_clk) disable iff (!nrst)
      (r.st == S_RUN && mismatch && !power_src && !pin_reset)
         |=> (!r.cm_flag && r.st == S_RELOAD && cfg_reload && !core_reset_n);
   endproperty
   a_mismatch_reset: assert property (p_mismatch_reset)
      else $error("mismatch did not reset and clear its flag");

   property p_pin_late_release;
      @(posedge sys_clk) disable iff (!nrst)
      (r.st == S_RELOAD && r.reload_seen && !pin_reset && !power_src)
         |=> (core_reset_n || power_src || pin_reset);
   endproperty
   a_pin_late_release: assert property (p_pin_late_release)
      else $error("core not released at once after pin release");

   property p_sync_release;
      @(posedge sys_clk) disable iff (!nrst)
      $rose(core_reset_n) |-> $past(r.st == S_RELOAD || r.st == S_RUN);
   endproperty
   a_sync_release: assert property (p_sync_release)
      else $error("core released outside the release sequence");

   property p_bor_restart;
      @(posedge sys_clk) disable iff (!nrst)
      ($fell(bor_eff) && !por_active) |=> (r.st == S_TIMER && r.put_cnt == '0);
   endproperty
   a_bor_restart: assert property (p_bor_restart)
      else $error("timer did not start from zero after brown-out");

   property p_bor_off;
      @(posedge sys_clk) disable iff (!nrst)
      (!regulator_enable_pin && !por_active && !pin_reset && !mismatch && r.st == S_RUN) |=> (r.st == S_RUN);
   endproperty
   a_bor_off: assert property (p_bor_off)
      else $error("reset taken with regulator off");

   property p_timer_after_pulse;
      @(posedge sys_clk) disable iff (!nrst)
      $rose(r.st == S_TIMER) |-> $past(r.st == S_POWER && !power_src);
   endproperty
   a_timer_after_pulse: assert property (p_timer_after_pulse)
      else $error("timer started during a power event");

   property p_run_after_reload;
      @(posedge sys_clk) disable iff (!nrst)
      $rose(r.st == S_RUN) |-> $past(r.st == S_RELOAD && (r.reload_seen || cfg_reload_done));
   endproperty
   a_run_after_reload: assert property (p_run_after_reload)
      else $error("core run without a configuration reload");

endmodule : reset_sequencer

`default_nettype wire

// ---- hw/reset_seq_pkg.sv ----
/*
 * Constants, state encoding and register layout for the reset source
 * merger and power-up timer.
 * Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
 */
package reset_seq_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 10;
   localparam int FILTER_NS      = 200;
   localparam int FILTER_CYCLES  = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILTER_W       = 5;
   localparam logic [FILTER_W-1:0] FILTER_LAST = FILTER_W'(FILTER_CYCLES - 1);
   localparam int RC_PERIOD_NS   = 32000;
   localparam int RC_TICK_CYCLES = RC_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TICK_W         = 12;
   localparam int PUT_W          = 11;
   localparam logic [PUT_W-1:0] PUT_LAST = 11'h7ff;

   // ---------------------------------------------------------------
   // Configuration compare
   // ---------------------------------------------------------------
   localparam int CFG_BITS = 32;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] OFS_FLAGS  = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
   localparam int BIT_BOR = 0;
   localparam int BIT_POR = 1;
   localparam int BIT_CM  = 5;
   localparam logic RST_BOR = 1'h0;
   localparam logic RST_POR = 1'h0;
   localparam logic RST_CM  = 1'h1;
   localparam int STS_POWER  = 0;
   localparam int STS_PIN    = 1;
   localparam int STS_TIMER  = 2;
   localparam int STS_RELOAD = 3;
   localparam int STS_CORE   = 4;
   localparam int STS_CNT_LSB = 16;

   // ---------------------------------------------------------------
   // Sequencer state
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      S_POWER  = 4'h1,
      S_TIMER  = 4'h2,
      S_RELOAD = 4'h4,
      S_RUN    = 4'h8
   } seq_state_t;

   typedef struct packed {
      seq_state_t        st;
      logic [TICK_W-1:0] tick_cnt;
      logic [PUT_W-1:0]  put_cnt;
      logic              reload_seen;
      logic              bor_flag;
      logic              por_flag;
      logic              cm_flag;
      logic              ack;
      logic [31:0]       rdata;
   } seq_regs_t;

endpackage : reset_seq_pkg

// ---- hw/pin_noise_filter.sv ----
/*
 * Noise filter for the external active-low reset pin.
 * Assumes the pin is already synchronous to sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_noise_filter
   import reset_seq_pkg::*;
(
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic nrst,
   // Pin and filtered request
   input  wire logic ext_reset_n_pin,
   output logic      pin_reset
);

   typedef struct packed {
      logic [FILTER_W-1:0] low_cnt;
      logic                hold;
   } filt_regs_t;

   filt_regs_t r;
   filt_regs_t next_r;

   // ---------------------------------------------------------------
   // Low time counter
   // ---------------------------------------------------------------
   always_comb begin
      next_r = r;
      if (ext_reset_n_pin) begin
         next_r.low_cnt = '0;
         next_r.hold    = 1'b0;
      end else if (r.low_cnt == FILTER_LAST) begin
         next_r.hold = 1'b1;
      end else begin
         next_r.low_cnt = r.low_cnt + FILTER_W'(1);
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign pin_reset = r.hold;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_short_low_ignored;
      @(posedge sys_clk) disable iff (!nrst)
      $rose(pin_reset) |-> ($past(r.low_cnt) == FILTER_LAST) && $past(!ext_reset_n_pin);
   endproperty
   a_short_low_ignored: assert property (p_short_low_ignored)
      else $error("pin reset taken before the filter time");

   property p_release_drops;
      @(posedge sys_clk) disable iff (!nrst)
      ext_reset_n_pin |=> !pin_reset;
   endproperty
   a_release_drops: assert property (p_release_drops)
      else $error("pin reset held after pin release");

endmodule : pin_noise_filter

`default_nettype wire

// ---- bench/supply_pin_model.sv ----
/*
 * Behavioural model of the supply monitors, the external reset pin
 * driver and the configuration store that answers reload requests.
 * Assumes the bench steers it through its want_ inputs at sys_clk edges.
 */
`timescale 1ns/1ps
`default_nettype none

module supply_pin_model (
   // Clock
   input  wire logic       sys_clk,
   // Requests from the bench
   input  wire logic       want_por,
   input  wire logic       want_brownout,
   input  wire logic       want_regulator,
   input  wire logic       want_pin_low,
   input  wire logic [3:0] reload_delay,
   // Monitor and pin levels
   output logic            por_active,
   output logic            brownout_detect,
   output logic            regulator_enable_pin,
   output logic            ext_reset_n_pin,
   // Configuration reload answer
   input  wire logic       cfg_reload,
   output logic            cfg_reload_done
);
   logic [3:0] wait_cnt;

   // -------------------------------------------------------------
   // Levels follow the bench one edge later
   // -------------------------------------------------------------
   always @(posedge sys_clk) begin
      por_active           <= want_por;
      brownout_detect      <= want_brownout;
      regulator_enable_pin <= want_regulator;
      ext_reset_n_pin      <= !want_pin_low;
   end

   // -------------------------------------------------------------
   // Reload answer, prompt or slow
   // -------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (cfg_reload === 1'b1 && !cfg_reload_done) begin
         if (wait_cnt >= reload_delay) begin
            cfg_reload_done <= 1'b1;
            wait_cnt        <= 4'h0;
         end else begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end else begin
         cfg_reload_done <= 1'b0;
         wait_cnt        <= 4'h0;
      end
   end
endmodule : supply_pin_model

`default_nettype wire

// ---- bench/reset_source_and_powerup_timer_bench.sv ----
/*
 * Self-checking bench for the reset sequencer: pin filter, supply
 * resets, power-up timer, mismatch reset and cause flags over Avalon-MM.
 * Assumes the package and design files and supply_pin_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, want) begin check_count++; if ((got) !== (want)) begin fail_count++; \
   $display("ERROR %0t: got %h want %h", $time, (got), (want)); end end

module reset_source_and_powerup_timer_bench
   import reset_seq_pkg::*;
   ;
   localparam int TICKS = 2;
   localparam int DELAY = 2048 * TICKS;

   logic                sys_clk, nrst, cfg_reload, cfg_reload_done, core_reset_n;
   logic                want_por, want_brownout, want_regulator, want_pin_low;
   logic                por_active, brownout_detect, regulator_enable_pin, ext_reset_n_pin;
   logic [3:0]          reload_delay, avs_byteenable;
   logic [CFG_BITS-1:0] cfg_words, cfg_shadow;
   logic [ADDR_W-1:0]   avs_address;
   logic                avs_read, avs_write, avs_waitrequest;
   logic [31:0]         avs_writedata, avs_readdata, rd, flags;
   int                  fail_count, check_count, seed, n, len, bad, cyc, t0, reloads, r0;

   supply_pin_model partner (.sys_clk(sys_clk), .want_por(want_por), .want_brownout(want_brownout),
      .want_regulator(want_regulator), .want_pin_low(want_pin_low), .reload_delay(reload_delay),
      .por_active(por_active), .brownout_detect(brownout_detect),
      .regulator_enable_pin(regulator_enable_pin), .ext_reset_n_pin(ext_reset_n_pin),
      .cfg_reload(cfg_reload), .cfg_reload_done(cfg_reload_done));

   reset_sequencer #(.TICK_CYCLES(TICKS)) uut (.sys_clk(sys_clk), .nrst(nrst), .por_active(por_active),
      .brownout_detect(brownout_detect), .regulator_enable_pin(regulator_enable_pin),
      .ext_reset_n_pin(ext_reset_n_pin), .cfg_words(cfg_words), .cfg_shadow(cfg_shadow),
      .cfg_reload(cfg_reload), .cfg_reload_done(cfg_reload_done), .core_reset_n(core_reset_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

   // ---------------------------------------------------------------
   // Clock, cycle count and reload count
   // ---------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cfg_reload === 1'b1 && cfg_reload_done === 1'b1) reloads <= reloads + 1;
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] after_event(input logic [31:0] f, input int kind);
      logic [31:0] r;
      r = f;
      if (kind == 1 || kind == 2) r[BIT_BOR] = 1'b0;
      if (kind == 2) r[BIT_POR] = 1'b0;
      if (kind == 3) r[BIT_CM] = 1'b0;
      return r;
   endfunction : after_event

   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      int guard;
      guard = 0;
      @(posedge sys_clk);
      avs_read       <= !wr;
      avs_write      <= wr;
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      do begin
         @(posedge sys_clk);
         guard++;
      end while (avs_waitrequest !== 1'b0 && guard < 50);
      if (guard >= 50) begin
         fail_count++;
         $display("ERROR %0t: bus timeout", $time);
      end
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic wait_core(input logic v, input int lim, output int cnt);
      cnt = 0;
      while (core_reset_n !== v && cnt < lim) begin
         @(negedge sys_clk);
         cnt++;
      end
   endtask : wait_core

   task automatic hold_core(input logic v, input int cycles, output int nbad);
      nbad = 0;
      repeat (cycles) begin
         @(negedge sys_clk);
         if (core_reset_n !== v) nbad++;
      end
   endtask : hold_core

   task automatic pulse(input int cycles);
      @(posedge sys_clk);
      want_pin_low <= 1'b1;
      repeat (cycles) @(posedge sys_clk);
      want_pin_low <= 1'b0;
   endtask : pulse

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict

   initial begin
      repeat (60000) @(posedge sys_clk);
      fail_count++;
      print_verdict();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      seed = 32'h5daddbcf;
      fail_count = 0;
      check_count = 0;
      cyc = 0;
      reloads = 0;
      nrst = 1'b0;
      {want_por, want_brownout, want_pin_low, want_regulator} = 4'h1;
      reload_delay = 4'($random(seed));
      cfg_words = $random(seed);
      cfg_shadow = ~cfg_words;
      {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      t0 = cyc;
      flags = 32'h20;
      bus(1'b0, OFS_FLAGS, 32'h0, 4'hf);
      `CHK(rd, flags)
      bus(1'b0, OFS_STATUS, 32'h0, 4'hf);
      `CHK(rd[STS_TIMER], 1'b1)
      `CHK(rd[STS_CORE], 1'b1)
      wait_core(1'b1, DELAY + 100, n);
      `CHK((cyc - t0) >= DELAY && (cyc - t0) < DELAY + 40, 1'b1)
      flags = 32'h23;
      bus(1'b1, OFS_FLAGS, flags, 4'hf);
      bus(1'b1, OFS_FLAGS, 32'h0, 4'he);
      bus(1'b1, 4'hc, 32'h0, 4'hf);
      bus(1'b0, OFS_FLAGS, 32'h0, 4'hf);
      `CHK(rd, flags)
      bus(1'b0, 4'h8, 32'h0, 4'hf);
      `CHK(rd, 32'h0)
      for (int i = 0; i < 6; i++) begin
         len = (i == 0) ? 19 : 1 + ($unsigned($random(seed)) % 19);
         fork
            pulse(len);
            hold_core(1'b1, len + 25, bad);
         join
         `CHK(bad, 0)
      end
      for (int i = 0; i < 2; i++) begin
         len = (i == 0) ? 20 : 20 + ($unsigned($random(seed)) % 40);
         r0 = reloads;
         pulse(len);
         repeat (2) @(negedge sys_clk);
         `CHK(core_reset_n, 1'b0)
         wait_core(1'b1, 60, n);
         `CHK(n < 60 && reloads > r0, 1'b1)
      end
      bus(1'b0, OFS_FLAGS, 32'h0, 4'hf);
      `CHK(rd, after_event(flags, 0))
      @(posedge sys_clk);
      want_brownout <= 1'b1;
      wait_core(1'b0, 5, n);
      `CHK(n <= 2, 1'b1)
      repeat (30) @(posedge sys_clk);
      want_brownout <= 1'b0;
      repeat (2000) @(posedge sys_clk);
      `CHK(core_reset_n, 1'b0)
      want_brownout <= 1'b1;
      repeat (10) @(posedge sys_clk);
      want_brownout <= 1'b0;
      t0 = cyc;
      wait_core(1'b1, DELAY + 100, n);
      `CHK((cyc - t0) >= DELAY && (cyc - t0) < DELAY + 40, 1'b1)
      flags = after_event(flags, 1);
      bus(1'b0, OFS_FLAGS, 32'h0, 4'hf);
      `CHK(rd, flags)
      flags = 32'h23;
      bus(1'b1, OFS_FLAGS, flags, 4'hf);
      want_regulator <= 1'b0;
      repeat (3) @(posedge sys_clk);
      want_brownout <= 1'b1;
      hold_core(1'b1, 50, bad);
      `CHK(bad, 0)
      @(posedge sys_clk);
      want_brownout <= 1'b0;
      bus(1'b0, OFS_FLAGS, 32'h0, 4'hf);
      `CHK(rd, flags)
      want_regulator <= 1'b1;
      @(posedge sys_clk);
      cfg_shadow <= cfg_shadow ^ (32'h1 << ($unsigned($random(seed)) % 32));
      wait_core(1'b0, 5, n);
      `CHK(n < 5, 1'b1)
      @(posedge sys_clk);
      cfg_shadow <= ~cfg_words;
      wait_core(1'b1, 60, n);
      `CHK(n < 60, 1'b1)
      flags = after_event(flags, 3);
      bus(1'b0, OFS_FLAGS, 32'h0, 4'hf);
      `CHK(rd, flags)
      flags = 32'h23;
      bus(1'b1, OFS_FLAGS, flags, 4'hf);
      for (int i = 0; i < 2; i++) begin
         @(posedge sys_clk);
         want_por <= 1'b1;
         want_pin_low <= (i == 1);
         reload_delay <= 4'hf;
         repeat (500) @(posedge sys_clk);
         want_por <= 1'b0;
         t0 = cyc;
         if (i == 0) begin
            wait_core(1'b1, DELAY + 100, n);
            `CHK((cyc - t0) >= DELAY && (cyc - t0) < DELAY + 40, 1'b1)
            flags = after_event(flags, 2);
            bus(1'b0, OFS_FLAGS, 32'h0, 4'hf);
            `CHK(rd, flags)
         end else begin
            repeat (DELAY + 80) @(posedge sys_clk);
            `CHK(core_reset_n, 1'b0)
            want_pin_low <= 1'b0;
            wait_core(1'b1, 20, n);
            `CHK(n <= 4, 1'b1)
         end
      end
      print_verdict();
   end
endmodule : reset_source_and_powerup_timer_bench

`default_nettype wire
